//--- design/frpi_consts.svh
// Opcodes, phase lengths and timing constants of the flash command block
`ifndef FRPI_CONSTS_SVH
`define FRPI_CONSTS_SVH

`define FRPI_OP_RESUME 8'h7A
`define FRPI_OP_SUSPEND 8'h75
`define FRPI_OP_PDOWN 8'hB9
`define FRPI_OP_WAKE_ID 8'hAB
`define FRPI_OP_MFR_DEV 8'h90
`define FRPI_OP_MFR_DEV2 8'h92
`define FRPI_OP_MFR_DEV4 8'h94
`define FRPI_OP_UNIQUE 8'h4B
`define FRPI_OP_IDENT 8'h9F
`define FRPI_OP_PTABLE 8'h5A

// Rising clock counts: opcode end, data output start per opcode, address end
`define FRPI_OPC_BITS 7'h08
`define FRPI_START_MFR_DEV 7'h20
`define FRPI_START_MFR_DEV2 7'h18
`define FRPI_START_MFR_DEV4 7'h12
`define FRPI_START_WAKE_ID 7'h20
`define FRPI_START_UNIQUE 7'h28
`define FRPI_START_IDENT 7'h08
`define FRPI_START_PTABLE 7'h28
`define FRPI_START_NONE 7'h7F
`define FRPI_ADDR_END 7'h20

// Timing in ns
`define FRPI_CLK_PERIOD_NS 8
`define FRPI_BUSY_RISE_NS 200
`define FRPI_PD_ENTRY_NS 3000
`define FRPI_WAKE_NS 3000
`define FRPI_WAKE_ID_NS 1800

`endif

//--- design/frpi_flash_cmd.sv
// Serial flash resume, power-down and identification command handler
`timescale 1ns/1ps
`default_nettype none
`include "frpi_consts.svh"

// Summary of operation
// - Resume 7Ah accepted only with suspend flag set and busy clear.
// - Resume clears suspend flag at once, raises busy within 200ns.
// - Resume with suspend clear or busy set is ignored, state unchanged.
// - Resume ignored when power loss ended the suspended state.
// - Power-down B9h acts only if chip select rises right after bit 8.
// - Power-down state entered within the entry time after chip select.
// - While powered down only ABh is recognised; all else ignored.
// - Device always starts in normal operation after power-up.
// - Bare ABh wakes after the wake delay; host holds select high.
// - ABh plus three dummy bytes streams device identifier MSB first.
// - ABh is ignored while busy, leaving the running cycle alone.
// - 90h with zero address returns manufacturer then device identifier.
// - 92h takes address two bits per clock, returns ids two per clock.
// - 94h: four dummy clocks, address four bits per clock, ids by four.
// - 4Bh plus four dummy bytes streams the 64-bit unique number.
// - 9Fh returns manufacturer, memory type and capacity bytes.
// - 5Ah streams parameter table from the fall of clock 40.
// - Parameter read uses low address byte as the start offset.
// - Opcode and address bits are latched on rising clock edges.
// - Suspend sets the suspend flag at once; engine drops busy later.
module frpi_flash_cmd #(
   parameter logic [7:0] MFR_ID = 8'h5C, // Arbitrary value
   parameter logic [7:0] DEV_ID = 8'h3A, // Arbitrary value
   parameter logic [7:0] MEM_TYPE = 8'h61, // Arbitrary value
   parameter logic [7:0] CAPACITY = 8'h17, // Arbitrary value
   parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89AB_CDEF // Arbitrary
) (
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_sck_i,
   input wire logic [3:0] spi_io_i,
   input wire logic busy_i,
   input wire logic power_loss_i,
   output logic [3:0] spi_io_o,
   output logic [3:0] spi_io_oe_o,
   output logic suspend_flag_o,
   output logic busy_o,
   output logic powered_down_o,
   output logic suspend_req_o,
   output logic resume_req_o
);

   localparam int BUSY_CYC = `FRPI_BUSY_RISE_NS / `FRPI_CLK_PERIOD_NS;
   localparam int PD_CYC = `FRPI_PD_ENTRY_NS / `FRPI_CLK_PERIOD_NS;
   localparam int WAKE_CYC = `FRPI_WAKE_NS / `FRPI_CLK_PERIOD_NS;
   localparam int WAKE_ID_CYC = `FRPI_WAKE_ID_NS / `FRPI_CLK_PERIOD_NS;

   frpi_pkg::frpi_state_t s;
   frpi_pkg::frpi_state_t next_s;

   function automatic logic [6:0] start_of(input logic [7:0] op);
      case (op)
         `FRPI_OP_MFR_DEV: start_of = `FRPI_START_MFR_DEV;
         `FRPI_OP_MFR_DEV2: start_of = `FRPI_START_MFR_DEV2;
         `FRPI_OP_MFR_DEV4: start_of = `FRPI_START_MFR_DEV4;
         `FRPI_OP_WAKE_ID: start_of = `FRPI_START_WAKE_ID;
         `FRPI_OP_UNIQUE: start_of = `FRPI_START_UNIQUE;
         `FRPI_OP_IDENT: start_of = `FRPI_START_IDENT;
         `FRPI_OP_PTABLE: start_of = `FRPI_START_PTABLE;
         default: start_of = `FRPI_START_NONE;
      endcase
   endfunction

   // Small fixed table: signature and header, all else erased
   function automatic logic [7:0] ptable(input logic [7:0] idx);
      case (idx)
         8'h00: ptable = 8'h53;
         8'h01: ptable = 8'h46;
         8'h02: ptable = 8'h44;
         8'h03: ptable = 8'h50;
         8'h04: ptable = 8'h00;
         8'h05: ptable = 8'h01;
         8'h06: ptable = 8'h00;
         default: ptable = 8'hFF;
      endcase
   endfunction

   function automatic logic [63:0] stream_of(input logic [7:0] op,
                                             input logic [7:0] a);
      case (op)
         `FRPI_OP_WAKE_ID: stream_of = {8{DEV_ID}};
         `FRPI_OP_UNIQUE: stream_of = UNIQUE_ID;
         `FRPI_OP_IDENT: stream_of = {MFR_ID, MEM_TYPE, CAPACITY, 40'h0};
         `FRPI_OP_PTABLE: stream_of = {ptable(a), 56'h0};
         default: stream_of = {4{MFR_ID, DEV_ID}};
      endcase
   endfunction

   logic sck_rise;
   logic sck_fall;
   logic cs_rise;
   logic cs_low;
   logic accept_resume;
   logic accept_suspend;

   always_comb begin
      next_s = s;
      // Three-stage sampler; a change counts once stages two and three agree
      next_s.s1 = frpi_pkg::frpi_pins_t'({spi_cs_n_i, spi_sck_i, spi_io_i});
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      next_s.f = (s.s2 & s.s3) | (s.f & (s.s2 | s.s3));
      cs_low = !next_s.f.cs_n;
      cs_rise = !s.f.cs_n && next_s.f.cs_n;
      sck_rise = cs_low && !s.f.sck && next_s.f.sck;
      sck_fall = cs_low && s.f.sck && !next_s.f.sck;
      accept_resume = 1'b0;
      accept_suspend = 1'b0;
      next_s.suspend_req = 1'b0;
      next_s.resume_req = 1'b0;

      if (sck_rise) begin
         // Input bits are taken on rising edges only
         if (s.cnt != 7'h7F) begin
            next_s.cnt = s.cnt + 7'h01;
         end
         case (s.st)
            frpi_pkg::FRPI_ST_OP: begin
               next_s.opcode = {s.opcode[6:0], next_s.f.io[0]};
               if (next_s.cnt == `FRPI_OPC_BITS) begin
                  if (s.pd && next_s.opcode != `FRPI_OP_WAKE_ID) begin
                     next_s.st = frpi_pkg::FRPI_ST_IGN;
                  end else if (busy_i &&
                               next_s.opcode == `FRPI_OP_WAKE_ID) begin
                     next_s.st = frpi_pkg::FRPI_ST_IGN;
                  end else begin
                     next_s.st = frpi_pkg::FRPI_ST_RUN;
                  end
               end
            end
            frpi_pkg::FRPI_ST_RUN: begin
               if (s.cnt < `FRPI_ADDR_END) begin
                  next_s.addr = {s.addr[6:0], next_s.f.io[0]};
               end
            end
            frpi_pkg::FRPI_ST_DATA: ;
            frpi_pkg::FRPI_ST_IGN: ;
            default: next_s.st = frpi_pkg::FRPI_ST_IGN;
         endcase
         // Data phase begins once the opcode's lead-in is complete
         if (next_s.st == frpi_pkg::FRPI_ST_RUN &&
             start_of(next_s.opcode) != `FRPI_START_NONE &&
             next_s.cnt == start_of(next_s.opcode)) begin
            next_s.st = frpi_pkg::FRPI_ST_DATA;
            next_s.sh = stream_of(next_s.opcode, next_s.addr);
            next_s.off = next_s.addr;
            next_s.bc = 3'h0;
         end
      end

      if (sck_fall && s.st == frpi_pkg::FRPI_ST_DATA) begin
         case (s.opcode)
            `FRPI_OP_MFR_DEV2: begin
               next_s.io_out = {2'b00, s.sh[63:62]};
               next_s.io_oe = 4'h3;
               next_s.sh = {s.sh[61:0], s.sh[63:62]};
            end
            `FRPI_OP_MFR_DEV4: begin
               next_s.io_out = s.sh[63:60];
               next_s.io_oe = 4'hF;
               next_s.sh = {s.sh[59:0], s.sh[63:60]};
            end
            default: begin
               // Single width: data on io1, MSB first
               next_s.io_out = {2'b00, s.sh[63], 1'b0};
               next_s.io_oe = 4'h2;
               next_s.sh = {s.sh[62:0], s.sh[63]};
               next_s.bc = s.bc + 3'h1;
               if (s.opcode == `FRPI_OP_PTABLE && s.bc == 3'h7) begin
                  // Offset rolls over naturally at the table's end
                  next_s.off = s.off + 8'h01;
                  next_s.sh = {ptable(next_s.off), 56'h0};
               end
            end
         endcase
      end

      if (cs_rise) begin
         if (s.st != frpi_pkg::FRPI_ST_IGN && s.cnt == `FRPI_OPC_BITS) begin
            case (s.opcode)
               `FRPI_OP_PDOWN: begin
                  // Only a frame of exactly eight bits takes effect
                  if (!s.pd) begin
                     next_s.tmode = frpi_pkg::FRPI_TM_ENTRY;
                     next_s.tmr = 12'(PD_CYC);
                  end
               end
               `FRPI_OP_WAKE_ID: begin
                  if (s.pd) begin
                     next_s.tmode = frpi_pkg::FRPI_TM_WAKE;
                     next_s.tmr = 12'(WAKE_CYC);
                  end
               end
               `FRPI_OP_SUSPEND: begin
                  accept_suspend = !s.pd && !s.suspend_flag && busy_i;
               end
               `FRPI_OP_RESUME: begin
                  // Any other state leaves everything untouched
                  accept_resume = !s.pd && s.suspend_flag &&
                                  !busy_i;
               end
               default: ;
            endcase
         end else if (s.st != frpi_pkg::FRPI_ST_IGN && s.pd &&
                      s.opcode == `FRPI_OP_WAKE_ID &&
                      s.cnt >= `FRPI_START_WAKE_ID) begin
            next_s.tmode = frpi_pkg::FRPI_TM_WAKE;
            next_s.tmr = 12'(WAKE_ID_CYC);
         end
         // Frame end rearms the decoder and releases the data lines
         next_s.st = frpi_pkg::FRPI_ST_OP;
         next_s.cnt = 7'h00;
         next_s.io_oe = 4'h0;
      end else if (!cs_low) begin
         next_s.st = frpi_pkg::FRPI_ST_OP;
         next_s.cnt = 7'h00;
         next_s.io_oe = 4'h0;
      end

      if (accept_suspend) begin
         next_s.suspend_flag = 1'b1;
         next_s.suspend_req = 1'b1;
      end
      if (accept_resume) begin
         next_s.suspend_flag = 1'b0;
         next_s.resume_req = 1'b1;
         next_s.busy_hold = 8'(BUSY_CYC);
      end else if (s.busy_hold != 8'h00) begin
         next_s.busy_hold = s.busy_hold - 8'h01;
      end
      // Covers the gap until the engine reports busy itself
      next_s.busy = busy_i || accept_resume || next_s.busy_hold != 8'h00;
      // Loss of power voids the suspended state; it outranks a new suspend
      if (power_loss_i) begin
         next_s.suspend_flag = 1'b0;
      end

      if (s.tmode != frpi_pkg::FRPI_TM_IDLE) begin
         if (s.tmr <= 12'h001) begin
            next_s.pd = (s.tmode == frpi_pkg::FRPI_TM_ENTRY);
            next_s.tmode = frpi_pkg::FRPI_TM_IDLE;
            next_s.tmr = 12'h000;
         end else begin
            next_s.tmr = s.tmr - 12'h001;
         end
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s <= '0;
         s.s1 <= 6'h20;
         s.s2 <= 6'h20;
         s.s3 <= 6'h20;
         s.f <= 6'h20;
         s.st <= frpi_pkg::FRPI_ST_OP;
         s.tmode <= frpi_pkg::FRPI_TM_IDLE;
      end else if (ce_i) begin
         s <= next_s;
      end
   end

   assign spi_io_o = s.io_out;
   assign spi_io_oe_o = s.io_oe;
   assign suspend_flag_o = s.suspend_flag;
   assign busy_o = s.busy;
   assign powered_down_o = s.pd;
   assign suspend_req_o = s.suspend_req;
   assign resume_req_o = s.resume_req;

   a_resume_accept_cond: assert property (@(posedge clock_i)
      disable iff (!rstn_i)
      $rose(resume_req_o) |-> $past(suspend_flag_o) && !$past(busy_i))
      else $error("resume taken without suspend or while busy");

   a_resume_effect: assert property (@(posedge clock_i)
      disable iff (!rstn_i)
      $rose(resume_req_o) |-> !suspend_flag_o && busy_o)
      else $error("resume did not clear suspend and raise busy");

   a_suspend_fall_cause: assert property (@(posedge clock_i)
      disable iff (!rstn_i)
      $fell(suspend_flag_o) |-> resume_req_o || $past(power_loss_i))
      else $error("suspend flag cleared without resume or power loss");

   a_loss_voids_resume: assert property (@(posedge clock_i)
      disable iff (!rstn_i)
      power_loss_i && ce_i |=> !suspend_flag_o)
      else $error("suspend flag survived power loss");

   a_pd_entry_timed: assert property (@(posedge clock_i)
      disable iff (!rstn_i)
      $rose(powered_down_o) |-> $past(s.tmode) == frpi_pkg::FRPI_TM_ENTRY)
      else $error("power-down entered without entry timer");

   a_pdown_exact_frame: assert property (@(posedge clock_i)
      disable iff (!rstn_i)
      $rose(s.tmode == frpi_pkg::FRPI_TM_ENTRY)
      |-> $past(s.opcode) == `FRPI_OP_PDOWN && $past(s.cnt) == `FRPI_OPC_BITS)
      else $error("power-down armed without an eight-bit frame");

   a_ptable_wrap: assert property (@(posedge clock_i)
      disable iff (!rstn_i)
      s.st == frpi_pkg::FRPI_ST_DATA && $past(s.st) == frpi_pkg::FRPI_ST_DATA
      && s.off != $past(s.off) |-> s.off == 8'($past(s.off) + 8'h01))
      else $error("table offset did not step by one");

   a_pd_only_wake: assert property (@(posedge clock_i)
      disable iff (!rstn_i)
      $past(s.st) == frpi_pkg::FRPI_ST_OP && s.st != frpi_pkg::FRPI_ST_OP
      && s.st != frpi_pkg::FRPI_ST_IGN
      && $past(s.pd) |-> s.opcode == `FRPI_OP_WAKE_ID)
      else $error("instruction other than wake decoded while down");

   a_busy_wake_ignored: assert property (@(posedge clock_i)
      disable iff (!rstn_i)
      $past(s.st) == frpi_pkg::FRPI_ST_OP && s.st != frpi_pkg::FRPI_ST_OP
      && s.opcode == `FRPI_OP_WAKE_ID && $past(busy_i)
      |-> s.st == frpi_pkg::FRPI_ST_IGN)
      else $error("wake/id accepted while busy");

   a_ptable_start: assert property (@(posedge clock_i)
      disable iff (!rstn_i)
      $rose(s.st == frpi_pkg::FRPI_ST_DATA) && s.opcode == `FRPI_OP_PTABLE
      |-> s.cnt == `FRPI_START_PTABLE && s.off == s.addr)
      else $error("parameter table output started at wrong clock");

   a_cs_rise_ends: assert property (@(posedge clock_i)
      disable iff (!rstn_i)
      $rose(s.f.cs_n) |-> s.st == frpi_pkg::FRPI_ST_OP && s.cnt == 7'h00
      && spi_io_oe_o == 4'h0)
      else $error("frame end did not rearm decoder");

endmodule
`default_nettype wire

//--- design/frpi_pkg.sv
// Types shared by the flash resume, power-down and identification block
package frpi_pkg;

   typedef enum logic [1:0] {
      FRPI_ST_OP = 2'b00,
      FRPI_ST_RUN = 2'b01,
      FRPI_ST_DATA = 2'b11,
      FRPI_ST_IGN = 2'b10
   } frpi_cmd_st_t;

   typedef enum logic [1:0] {
      FRPI_TM_IDLE = 2'b00,
      FRPI_TM_ENTRY = 2'b01,
      FRPI_TM_WAKE = 2'b11
   } frpi_tmode_t;

   typedef struct packed {
      logic cs_n;
      logic sck;
      logic [3:0] io;
   } frpi_pins_t;

   typedef struct packed {
      frpi_pins_t s1;
      frpi_pins_t s2;
      frpi_pins_t s3;
      frpi_pins_t f;
      frpi_cmd_st_t st;
      logic [6:0] cnt;
      logic [7:0] opcode;
      logic [7:0] addr;
      logic [63:0] sh;
      logic [2:0] bc;
      logic [7:0] off;
      logic [3:0] io_out;
      logic [3:0] io_oe;
      logic pd;
      frpi_tmode_t tmode;
      logic [11:0] tmr;
      logic suspend_flag;
      logic [7:0] busy_hold;
      logic busy;
      logic suspend_req;
      logic resume_req;
   } frpi_state_t;

endpackage

//--- design/frpi_unused_placeholder_removed.sv
// Intentionally empty file: no additional design content
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- test/frpi_host.sv
// SPI host model that frames flash instructions for the command block
`timescale 1ns/1ps
`default_nettype none
module frpi_host (
   input wire logic clock_i,
   input wire logic [3:0] dev_io_i,
   input wire logic [3:0] dev_oe_i,
   output logic cs_n_o,
   output logic sck_o,
   output logic [3:0] io_o,
   output logic oe_seen_o,
   output logic [63:0] q_o
);
   logic [63:0] d;
   initial begin
      cs_n_o = 1'b1;
      sck_o = 1'b0;
      io_o = 4'h0;
      oe_seen_o = 1'b0;
      q_o = '0;
      d = '0;
   end
   // Eight system clocks a level, since the block filters the pins
   task automatic half();
      repeat (8) @(posedge clock_i);
      #1;
      oe_seen_o = oe_seen_o | (|dev_oe_i);
   endtask
   // Released lines toggle so stale data never looks valid
   task automatic sclk(input int wi, input int wo);
      sck_o = 1'b0;
      if (wi > 0) begin
         io_o = d[63:60] >> (4 - wi);
         d = d << wi;
      end else begin
         io_o = ~io_o;
      end
      half();
      case (wo)
         1: q_o = {q_o[62:0], dev_io_i[1]};
         2: q_o = {q_o[61:0], dev_io_i[1:0]};
         4: q_o = {q_o[59:0], dev_io_i};
         default: ;
      endcase
      sck_o = 1'b1;
      half();
   endtask
   task automatic frame(input logic [7:0] op, input int n_in,
         input logic [63:0] din, input int wi, input int n_out,
         input int wo);
      oe_seen_o = 1'b0;
      q_o = '0;
      d = {op, 56'h0};
      cs_n_o = 1'b0;
      half();
      for (int i = 0; i < 8; i++) begin
         sclk(1, 0);
      end
      d = din;
      for (int i = 0; i < n_in; i++) begin
         sclk(wi, 0);
      end
      for (int i = 0; i < n_out; i++) begin
         sclk(0, wo);
      end
      sck_o = 1'b0;
      half();
      cs_n_o = 1'b1;
      io_o = ~io_o;
      half();
   endtask
endmodule
`default_nettype wire

//--- test/tb.sv
// Self-checking bench for the flash resume, power-down and id block
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam logic [7:0] MFR = 8'hC3; // Arbitrary value
   localparam logic [7:0] DEV = 8'h5E; // Arbitrary value
   localparam logic [7:0] MT = 8'h42; // Arbitrary value
   localparam logic [7:0] CAP = 8'h16; // Arbitrary value
   localparam logic [63:0] UID = 64'hA5A5_0F0F_1234_8765; // Arbitrary
   logic clock_i = 1'b0;
   logic rstn_i = 1'b0;
   logic busy_i = 1'b0;
   logic power_loss_i = 1'b0;
   logic cs_n, sck, oe_seen, sfl, busy_o, pd, sreq, rreq;
   logic [3:0] hio, io_i, io_o, io_oe;
   logic [63:0] q;
   int err_count = 0;
   int samples_checked = 0;
   int cyc = 0;
   int rcnt = 0;
   int scnt = 0;
   always #4 clock_i = ~clock_i;
   // Shared data wire: whoever enables wins
   assign io_i = (io_oe & io_o) | (~io_oe & hio);
   frpi_flash_cmd #(.MFR_ID(MFR), .DEV_ID(DEV), .MEM_TYPE(MT),
      .CAPACITY(CAP), .UNIQUE_ID(UID)) dut (
      .clock_i(clock_i), .rstn_i(rstn_i), .ce_i(1'b1),
      .spi_cs_n_i(cs_n), .spi_sck_i(sck), .spi_io_i(io_i),
      .busy_i(busy_i), .power_loss_i(power_loss_i),
      .spi_io_o(io_o), .spi_io_oe_o(io_oe), .suspend_flag_o(sfl),
      .busy_o(busy_o), .powered_down_o(pd), .suspend_req_o(sreq),
      .resume_req_o(rreq));
   frpi_host host (.clock_i(clock_i), .dev_io_i(io_o),
      .dev_oe_i(io_oe), .cs_n_o(cs_n), .sck_o(sck), .io_o(hio),
      .oe_seen_o(oe_seen), .q_o(q));
   // Pulses are counted away from the edge that launches them
   always @(negedge clock_i) begin
      if (rreq === 1'b1) rcnt++;
      if (sreq === 1'b1) scnt++;
   end
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 60000) begin
         err_count++;
         final_report();
      end
   end
   task automatic step(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   task automatic chk_data(input logic [63:0] got, input logic [63:0] exp,
         input string m);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp, input string m);
      chk_data({63'h0, got}, {63'h0, exp}, m);
   endtask
   task automatic wait_pd(input logic v);
      for (int n = 0; n < 400 && pd !== v; n++) begin
         step(1);
      end
   endtask
   task automatic t_reset();
      chk_data({sfl, busy_o, pd, sreq, rreq, io_oe}, 0, "reset");
   endtask
   task automatic t_single_ids();
      host.frame(8'h90, 24, 0, 1, 16, 1);
      chk_data(q, {MFR, DEV}, "mfr dev");
      host.frame(8'hAB, 24, 0, 1, 24, 1);
      chk_data(q, {DEV, DEV, DEV}, "dev id");
      host.frame(8'h4B, 32, 0, 1, 64, 1);
      chk_data(q, UID, "unique");
      host.frame(8'h9F, 0, 0, 1, 24, 1);
      chk_data(q, {MFR, MT, CAP}, "ident");
      chk_bit(|io_oe, 1'b0, "oe after cs");
   endtask
   task automatic t_wide_ids();
      host.frame(8'h92, 16, 64'h0000_00F0_0000_0000, 2, 16, 2);
      chk_data(q, {MFR, DEV, MFR, DEV}, "dual id");
      host.frame(8'h94, 10, 0, 4, 16, 4);
      chk_data(q, {4{MFR, DEV}}, "quad id");
   endtask
   task automatic t_table();
      host.frame(8'h5A, 32, 0, 1, 40, 1);
      chk_data(q, 64'h53_4644_5000, "table 0");
      host.frame(8'h5A, 32, 64'h0000_FE00_0000_0000, 1, 24, 1);
      chk_data(q, 64'hFF_FF53, "table wrap");
   endtask
   task automatic t_resume();
      host.frame(8'h7A, 0, 0, 1, 0, 1);
      chk_data({sfl, busy_o, 8'(rcnt)}, 0, "resume idle");
      busy_i = 1'b1;
      host.frame(8'h75, 0, 0, 1, 0, 1);
      chk_data({sfl, 8'(scnt)}, 9'h101, "suspend");
      host.frame(8'h7A, 0, 0, 1, 0, 1);
      chk_data({sfl, 8'(rcnt)}, 9'h100, "resume busy");
      busy_i = 1'b0;
      step(2);
      host.frame(8'h7A, 0, 0, 1, 0, 1);
      chk_data({sfl, busy_o, 8'(rcnt)}, 10'h101, "resume");
      step(30);
      chk_bit(busy_o, 1'b0, "busy follows engine");
   endtask
   task automatic t_powerloss();
      busy_i = 1'b1;
      host.frame(8'h75, 0, 0, 1, 0, 1);
      busy_i = 1'b0;
      power_loss_i = 1'b1;
      step(1);
      power_loss_i = 1'b0;
      step(1);
      chk_bit(sfl, 1'b0, "loss clears");
      host.frame(8'h7A, 0, 0, 1, 0, 1);
      chk_data(8'(rcnt), 8'h01, "resume after loss");
   endtask
   task automatic t_powerdown();
      host.frame(8'hB9, 1, 0, 1, 0, 1);
      step(400);
      chk_bit(pd, 1'b0, "long pdown");
      host.frame(8'hB9, 0, 0, 1, 0, 1);
      wait_pd(1'b1);
      chk_bit(pd, 1'b1, "pdown entry");
      host.frame(8'h9F, 0, 0, 1, 24, 1);
      chk_bit(oe_seen, 1'b0, "ident while down");
      host.frame(8'hAB, 0, 0, 1, 0, 1);
      wait_pd(1'b0);
      chk_bit(pd, 1'b0, "wake");
      busy_i = 1'b1;
      host.frame(8'hAB, 24, 0, 1, 16, 1);
      chk_bit(oe_seen, 1'b0, "id while busy");
      busy_i = 1'b0;
   endtask
   task automatic t_wake_id();
      host.frame(8'hB9, 0, 0, 1, 0, 1);
      wait_pd(1'b1);
      chk_bit(pd, 1'b1, "pdown again");
      host.frame(8'hAB, 24, 0, 1, 16, 1);
      chk_data(q, {DEV, DEV}, "id while down");
      step(200);
      chk_bit(pd, 1'b1, "wake id early");
      step(30);
      chk_bit(pd, 1'b0, "wake id done");
   endtask
   task automatic final_report();
      $display("Checks %0d, errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      step(3);
      rstn_i = 1'b1;
      step(4);
      t_reset();
      t_single_ids();
      t_wide_ids();
      t_table();
      t_resume();
      t_powerloss();
      t_powerdown();
      t_wake_id();
      final_report();
   end
endmodule
`default_nettype wire
